// ===== cif_regs.svh
// register addresses, field positions, vectors and reset values of the
// interrupt and flag block; assumes an 8-bit data-memory address space.
`ifndef CIF_REGS_SVH
`define CIF_REGS_SVH
`define CIF_STATUS_ADDR   8'h0a
`define CIF_CTRL_ADDR     8'h0b
`define CIF_GIE_BIT       0
`define CIF_EN_LSB        1
`define CIF_FLAG_LSB      4
`define CIF_C_BIT         0
`define CIF_NIBBLE_BIT    1
`define CIF_Z_BIT         2
`define CIF_WRAP_BIT      3
`define CIF_HALT_FLAG_BIT 4
`define CIF_WDT_FLAG_BIT  5
`define CIF_VEC_EXT       8'h04
`define CIF_VEC_TMR0      8'h08
`define CIF_VEC_TMR1      8'h0c
`define CIF_STACK_DEPTH   5'h10
`define CIF_DEPTH_RST     5'h00
`define CIF_BYTE_RST      8'h00
`define CIF_NSRC          3
`endif

// ===== cif_pkg.sv
// types shared by the interrupt and flag block; constants live in the
// register header.
package cif_pkg;
  // flag results from the arithmetic unit, one valid per field
  typedef struct packed {
    logic upd_carry;
    logic upd_nibble;
    logic upd_zero;
    logic upd_wrap;
    logic carry;
    logic nibble_out_bit;
    logic zero;
    logic signed_wrap_bit;
  } cif_alu_flags_t;

  // core power state
  typedef enum logic [0:0] {
    CIF_RUN  = 1'b0,
    CIF_HALT = 1'b1
  } cif_mode_t;
endpackage : cif_pkg

// ===== cif_core.sv
// interrupt control and status flags of an 8-bit core.
// assumes the sequencer supplies op strobes, the fourth-phase pulse and the
// arithmetic flag results, all synchronous to I_SYS_CLK.
`timescale 1ns/100ps
`include "cif_regs.svh"
module cif_core (
  input  wire logic                    I_SYS_CLK,
  input  wire logic                    I_SRST,
  input  wire logic                    I_CE,
  input  wire logic                    I_EXT_IRQ_N,
  input  wire logic                    I_TMR0_OVF,
  input  wire logic                    I_TMR1_OVF,
  input  wire logic                    I_FOURTH_PHASE_PULSE,
  input  wire logic [7:0]              I_REG_ADDR,
  input  wire logic                    I_REG_WE,
  input  wire logic [7:0]              I_REG_WDATA,
  input  wire logic                    I_SUB_CALL,
  input  wire logic                    I_SUB_EXIT_OP,
  input  wire logic                    I_IRQ_EXIT_OP,
  input  wire logic                    I_HALT_OP,
  input  wire logic                    I_WDT_CLEAR_OP,
  input  wire logic                    I_WDT_TIMEOUT,
  input  wire cif_pkg::cif_alu_flags_t I_ALU_FLAGS,
  output logic [7:0]                   O_REG_RDATA,
  output logic                         O_IRQ_CALL,
  output logic [7:0]                   O_IRQ_VECTOR,
  output logic                         O_STACK_FULL,
  output logic                         O_HALTED,
  output logic                         O_WAKE
);

  logic                  pin_prev_reg;
  logic [`CIF_NSRC-1:0]  set_vec;
  logic [`CIF_NSRC-1:0]  flag_reg;
  logic [`CIF_NSRC-1:0]  en_reg;
  logic                  gie_reg;
  logic [`CIF_NSRC-1:0]  pend;
  logic [`CIF_NSRC-1:0]  sel;
  logic                  svc;
  logic [4:0]            depth_reg;
  logic [4:0]            depth_next;
  logic                  wr_ctrl;
  logic                  wr_status;
  logic                  c_reg;
  logic                  nib_reg;
  logic                  z_reg;
  logic                  wrap_reg;
  logic                  halt_flag_reg;
  logic                  wdt_flag_reg;
  logic [`CIF_NSRC-1:0]  wake_mask_reg;
  cif_pkg::cif_mode_t    mode_reg;
  logic                  call_reg;
  logic [7:0]            vec_reg;
  logic                  full_reg;
  logic                  wake_reg;
  logic [7:0]            rdata_reg;

  assign wr_ctrl   = I_CE & I_REG_WE & (I_REG_ADDR == `CIF_CTRL_ADDR);
  assign wr_status = I_CE & I_REG_WE & (I_REG_ADDR == `CIF_STATUS_ADDR);

  // falling-edge detect; pin is taken as synchronous to the clock
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      pin_prev_reg <= 1'b1;
    end else if (I_CE) begin
      pin_prev_reg <= I_EXT_IRQ_N;
    end
  end

  // request events, index 0 is highest priority
  assign set_vec = {I_TMR1_OVF, I_TMR0_OVF,
                    pin_prev_reg & ~I_EXT_IRQ_N};

  // service decision only at the fourth-phase pulse
  always_comb begin
    pend = flag_reg & en_reg & {`CIF_NSRC{gie_reg}};
    sel  = pend & (~pend + 3'b001);
    svc  = I_CE & I_FOURTH_PHASE_PULSE & ~full_reg
           & (|pend);
  end

  // request flags: hardware set wins over software clear and acknowledge
  generate
    for (genvar i = 0; i < `CIF_NSRC; i++) begin : g_src
      always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
          flag_reg[i] <= 1'b0;
        end else if (I_CE) begin
          if (set_vec[i]) begin
            flag_reg[i] <= 1'b1;
          end else if (svc && sel[i]) begin
            flag_reg[i] <= 1'b0;
          end else if (wr_ctrl) begin
            flag_reg[i] <= I_REG_WDATA[`CIF_FLAG_LSB+i];
          end
        end
      end
    end
  endgenerate

  // per-source enables, software only
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      en_reg <= 3'b000;
    end else if (wr_ctrl) begin
      en_reg <= I_REG_WDATA[`CIF_EN_LSB +: `CIF_NSRC];
    end
  end

  // global enable; acknowledge is checked first so it wins over a return
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      gie_reg <= 1'b0;
    end else if (I_CE) begin
      if (svc) begin
        gie_reg <= 1'b0;
      end else if (I_IRQ_EXIT_OP) begin
        gie_reg <= 1'b1;
      end else if (wr_ctrl) begin
        gie_reg <= I_REG_WDATA[`CIF_GIE_BIT];
      end
    end
  end

  // return stack occupancy; a call on a full stack loses the oldest entry
  always_comb begin
    depth_next = depth_reg;
    if ((svc || I_SUB_CALL) && !(I_SUB_EXIT_OP || I_IRQ_EXIT_OP)) begin
      if (depth_reg != `CIF_STACK_DEPTH) begin
        depth_next = depth_reg + 5'h01;
      end
    end else if (!(svc || I_SUB_CALL)
                 && (I_SUB_EXIT_OP || I_IRQ_EXIT_OP)) begin
      if (depth_reg != `CIF_DEPTH_RST) begin
        depth_next = depth_reg - 5'h01;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      depth_reg <= `CIF_DEPTH_RST;
      full_reg  <= 1'b0;
    end else if (I_CE) begin
      depth_reg <= depth_next;
      full_reg  <= (depth_next == `CIF_STACK_DEPTH);
    end
  end

  // call pulse and vector to the sequencer; only the pc is pushed there
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      call_reg <= 1'b0;
      vec_reg  <= `CIF_BYTE_RST;
    end else if (I_CE) begin
      call_reg <= svc;
      if (svc) begin
        case (sel)
          3'b001:  vec_reg <= `CIF_VEC_EXT;
          3'b010:  vec_reg <= `CIF_VEC_TMR0;
          3'b100:  vec_reg <= `CIF_VEC_TMR1;
          default: vec_reg <= vec_reg;
        endcase
      end
    end
  end

  // arithmetic flags; an alu result beats a same-cycle software write
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      c_reg    <= 1'b0;
      nib_reg  <= 1'b0;
      z_reg    <= 1'b0;
      wrap_reg <= 1'b0;
    end else if (I_CE) begin
      if (I_ALU_FLAGS.upd_carry) begin
        c_reg <= I_ALU_FLAGS.carry;
      end else if (wr_status) begin
        c_reg <= I_REG_WDATA[`CIF_C_BIT];
      end
      if (I_ALU_FLAGS.upd_nibble) begin
        nib_reg <= I_ALU_FLAGS.nibble_out_bit;
      end else if (wr_status) begin
        nib_reg <= I_REG_WDATA[`CIF_NIBBLE_BIT];
      end
      if (I_ALU_FLAGS.upd_zero) begin
        z_reg <= I_ALU_FLAGS.zero;
      end else if (wr_status) begin
        z_reg <= I_REG_WDATA[`CIF_Z_BIT];
      end
      if (I_ALU_FLAGS.upd_wrap) begin
        wrap_reg <= I_ALU_FLAGS.signed_wrap_bit;
      end else if (wr_status) begin
        wrap_reg <= I_REG_WDATA[`CIF_WRAP_BIT];
      end
    end
  end

  // power-down and expiry flags ignore status writes entirely
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      halt_flag_reg <= 1'b0;
      wdt_flag_reg  <= 1'b0;
    end else if (I_CE) begin
      if (I_HALT_OP) begin
        halt_flag_reg <= 1'b1;
      end else if (I_WDT_CLEAR_OP) begin
        halt_flag_reg <= 1'b0;
      end
      if (I_WDT_TIMEOUT) begin
        wdt_flag_reg <= 1'b1;
      end else if (I_WDT_CLEAR_OP || I_HALT_OP) begin
        wdt_flag_reg <= 1'b0;
      end
    end
  end

  // power state; flags already up at entry are masked from waking
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      mode_reg      <= cif_pkg::CIF_RUN;
      wake_mask_reg <= 3'b000;
      wake_reg      <= 1'b0;
    end else if (I_CE) begin
      wake_reg <= 1'b0;
      case (mode_reg)
        cif_pkg::CIF_RUN: begin
          if (I_HALT_OP) begin
            mode_reg      <= cif_pkg::CIF_HALT;
            wake_mask_reg <= ~flag_reg;
          end
        end
        cif_pkg::CIF_HALT: begin
          if (|(set_vec & wake_mask_reg)) begin
            mode_reg <= cif_pkg::CIF_RUN;
            wake_reg <= 1'b1;
          end
        end
        default: mode_reg <= cif_pkg::CIF_RUN;
      endcase
    end
  end

  // read data, one cycle after the address; unused bits read zero
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      rdata_reg <= `CIF_BYTE_RST;
    end else if (I_CE) begin
      case (I_REG_ADDR)
        `CIF_STATUS_ADDR: rdata_reg <= {2'b00, wdt_flag_reg,
                                        halt_flag_reg, wrap_reg, z_reg,
                                        nib_reg, c_reg};
        `CIF_CTRL_ADDR:   rdata_reg <= {1'b0, flag_reg, en_reg,
                                        gie_reg};
        default:          rdata_reg <= `CIF_BYTE_RST;
      endcase
    end
  end

  assign O_REG_RDATA  = rdata_reg;
  assign O_IRQ_CALL   = call_reg;
  assign O_IRQ_VECTOR = vec_reg;
  assign O_STACK_FULL = full_reg;
  assign O_HALTED     = mode_reg;
  assign O_WAKE       = wake_reg;

  // checks on the design's own behaviour
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);

  sequence s_ext_edge;
    I_CE && pin_prev_reg && !I_EXT_IRQ_N;
  endsequence

  sequence s_halt_entry;
    I_CE && (mode_reg == cif_pkg::CIF_RUN) && I_HALT_OP;
  endsequence

  a_ext_edge_flag: assert property (
    s_ext_edge |=> flag_reg[0])
    else $error("external edge did not set request flag");

  a_call_clears_gie: assert property (
    svc |=> O_IRQ_CALL && !gie_reg)
    else $error("acknowledge did not clear global enable");

  a_full_holds_off: assert property (
    I_CE && full_reg |=> !O_IRQ_CALL)
    else $error("call issued with full stack");

  a_gie_low_blocks: assert property (
    I_CE && !gie_reg |=> !O_IRQ_CALL)
    else $error("call issued with global enable low");

  a_push_on_ack: assert property (
    svc && !I_SUB_CALL && !I_SUB_EXIT_OP && !I_IRQ_EXIT_OP
    |=> depth_reg == $past(depth_reg) + 5'h01)
    else $error("acknowledge did not push");

  a_irq_exit_op_sets_gie: assert property (
    I_CE && I_IRQ_EXIT_OP && !svc |=> gie_reg)
    else $error("interrupt return left global enable low");

  a_ret_keeps_gie: assert property (
    I_CE && I_SUB_EXIT_OP && !I_IRQ_EXIT_OP && !svc && !wr_ctrl
    |=> gie_reg == $past(gie_reg))
    else $error("plain return changed global enable");

  a_call_at_phase: assert property (
    O_IRQ_CALL |-> $past(I_FOURTH_PHASE_PULSE))
    else $error("call away from fourth-phase pulse");

  a_ext_first_prio: assert property (
    svc && pend[0] |=> O_IRQ_VECTOR == `CIF_VEC_EXT)
    else $error("external request lost priority");

  a_tmr1_vector: assert property (
    svc && (pend == 3'b100) |=> O_IRQ_VECTOR == `CIF_VEC_TMR1)
    else $error("timer 1 vector wrong");

  a_flag_held: assert property (
    I_CE && flag_reg[1] && !(svc && sel[1]) && !wr_ctrl |=> flag_reg[1])
    else $error("request flag dropped without service");

  a_single_ack: assert property (
    svc && pend[0] && pend[1] |=> flag_reg[1])
    else $error("lower priority flag cleared too");

  a_status_wr_keep: assert property (
    wr_status && !I_HALT_OP && !I_WDT_CLEAR_OP && !I_WDT_TIMEOUT
    |=> halt_flag_reg == $past(halt_flag_reg)
        && wdt_flag_reg == $past(wdt_flag_reg))
    else $error("status write touched power flags");

  a_zero_update: assert property (
    I_CE && I_ALU_FLAGS.upd_zero |=> z_reg == $past(I_ALU_FLAGS.zero))
    else $error("zero flag not updated");

  a_halt_sets_flag: assert property (
    I_CE && I_HALT_OP
    |=> halt_flag_reg && (wdt_flag_reg == $past(I_WDT_TIMEOUT)))
    else $error("halt did not set power-down flag");

  a_masked_no_wake: assert property (
    s_halt_entry ##2 (I_CE && (set_vec == 3'b100) && !wake_mask_reg[2])
    |=> !O_WAKE)
    else $error("pre-set flag woke the core");

  a_wake_on_event: assert property (
    I_CE && O_HALTED && |(set_vec & wake_mask_reg) |=> O_WAKE && !O_HALTED)
    else $error("interrupt event did not wake");

endmodule : cif_core

// ===== cif_seq_model.sv
// sequencer and return stack model standing beside the interrupt block.
// assumes op requests from the bench arrive as one-cycle pulses on i_clk.
`timescale 1ns/100ps
module cif_seq_model (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_call,
  input  wire logic       i_sret,
  input  wire logic       i_iret,
  input  wire logic       i_irq_call,
  output logic            o_sub_call,
  output logic            o_sub_exit,
  output logic            o_irq_exit,
  output logic [4:0]      o_depth
);
  // op strobes pass straight through to the block
  assign o_sub_call = i_call;
  assign o_sub_exit = i_sret;
  assign o_irq_exit = i_iret;

  // occupancy of the pc stack; an acknowledge pushes the pc and nothing else
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_depth <= 5'h00;
    end else if ((i_call | i_irq_call) && !(i_sret | i_iret)) begin
      // a call on a full stack drops the oldest entry, depth stays
      if (o_depth != 5'h10) o_depth <= o_depth + 5'h01;
    end else if ((i_sret | i_iret) && !(i_call | i_irq_call)) begin
      if (o_depth != 5'h00) o_depth <= o_depth - 5'h01;
    end
  end
endmodule : cif_seq_model

// ===== tb_cif_core.sv
// self-checking bench for the interrupt and flag block.
// assumes the sequencer model drives the op strobes and tracks stack depth.
`timescale 1ns/100ps
module tb_cif_core;
  localparam logic [8:0] P_FP = 9'h001, P_T0 = 9'h002, P_T1 = 9'h004;
  localparam logic [8:0] P_SC = 9'h008, P_SR = 9'h010, P_RT = 9'h020;
  localparam logic [8:0] P_HL = 9'h040, P_WC = 9'h080, P_WT = 9'h100;
  logic       clk, srst, pin_n, ovf0, ovf1, fp, we, halt, wclr, wto;
  logic       call_r, sret_r, iret_r, sc, se, ie, icall, sfull, halted, wake;
  logic       ce;
  logic [7:0] addr, wdata, rdata, vec;
  logic [4:0] depth;
  cif_pkg::cif_alu_flags_t alu;
  int         n_mismatch, num_checks, cyc;

  cif_core u_dut (.I_SYS_CLK(clk), .I_SRST(srst), .I_CE(ce),
    .I_EXT_IRQ_N(pin_n), .I_TMR0_OVF(ovf0), .I_TMR1_OVF(ovf1),
    .I_FOURTH_PHASE_PULSE(fp), .I_REG_ADDR(addr), .I_REG_WE(we),
    .I_REG_WDATA(wdata), .I_SUB_CALL(sc), .I_SUB_EXIT_OP(se),
    .I_IRQ_EXIT_OP(ie), .I_HALT_OP(halt), .I_WDT_CLEAR_OP(wclr),
    .I_WDT_TIMEOUT(wto), .I_ALU_FLAGS(alu), .O_REG_RDATA(rdata),
    .O_IRQ_CALL(icall), .O_IRQ_VECTOR(vec), .O_STACK_FULL(sfull),
    .O_HALTED(halted), .O_WAKE(wake));
  cif_seq_model u_seq (.i_clk(clk), .i_srst(srst), .i_call(call_r),
    .i_sret(sret_r), .i_iret(iret_r), .i_irq_call(icall),
    .o_sub_call(sc), .o_sub_exit(se), .o_irq_exit(ie), .o_depth(depth));

  // free-running clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard; every scenario together takes well under 1000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    we    <= 1'b1;
    wdata <= d;
    @(posedge clk);
    we    <= 1'b0;
  endtask : wr

  // read data lands at the edge that samples the address, one cycle after it is driven
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 chk(rdata, e);
  endtask : rd

  // one-cycle strobes by mask; outputs are looked at after the taking edge
  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    {wto, wclr, halt, iret_r, sret_r, call_r, ovf1, ovf0, fp} <= m;
    @(posedge clk);
    {wto, wclr, halt, iret_r, sret_r, call_r, ovf1, ovf0, fp} <= 9'h000;
    alu <= '0;
    #1;
  endtask : pulse

  task automatic pin_fall();
    @(posedge clk);
    pin_n <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    pin_n <= 1'b1;
  endtask : pin_fall

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1 chk({icall, sfull, halted, wake, 4'h0}, 8'h00);
  endtask : do_reset

  // reset values, read-only bits, unmapped place, alu flag loads
  task automatic t_regs();
    do_reset();
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h7f);
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h0f);
    wr(8'h0c, 8'haa);
    rd(8'h0c, 8'h00);
    wr(8'h0b, 8'h70);
    rd(8'h0b, 8'h70);
    @(posedge clk) alu <= cif_pkg::cif_alu_flags_t'(8'hfa);
    rd(8'h0a, 8'h05);
    @(posedge clk) alu <= cif_pkg::cif_alu_flags_t'(8'hf5);
    rd(8'h0a, 8'h0a);
  endtask : t_regs

  // external request, masking inside the routine, both kinds of return
  task automatic t_ext();
    do_reset();
    wr(8'h0b, 8'h03);
    pin_fall();
    rd(8'h0b, 8'h13);
    chk({7'h0, icall}, 8'h00);
    pulse(P_FP);
    chk({7'h0, icall}, 8'h01);
    chk(vec, 8'h04);
    rd(8'h0b, 8'h02);
    chk({3'h0, depth}, 8'h01);
    pin_fall();
    pulse(P_FP);
    chk({7'h0, icall}, 8'h00);
    rd(8'h0b, 8'h12);
    pulse(P_SC);
    pulse(P_SR);
    rd(8'h0b, 8'h12);
    pulse(P_RT);
    pulse(P_FP);
    chk({7'h0, icall}, 8'h01);
    pin_fall();
    wr(8'h0b, 8'h13);
    pulse(P_FP);
    chk({7'h0, icall}, 8'h01);
  endtask : t_ext

  // three pending sources, one served per service point
  task automatic t_prio();
    do_reset();
    wr(8'h0b, 8'h0f);
    pin_fall();
    pulse(P_T0 | P_T1);
    pulse(P_FP);
    chk(vec, 8'h04);
    rd(8'h0b, 8'h6e);
    pulse(P_RT);
    pulse(P_FP);
    chk(vec, 8'h08);
    pulse(P_RT);
    pulse(P_FP);
    chk(vec, 8'h0c);
    rd(8'h0b, 8'h0e);
  endtask : t_prio

  // full stack holds off service until one level is popped
  task automatic t_stack();
    do_reset();
    wr(8'h0b, 8'h05);
    repeat (16) pulse(P_SC);
    @(posedge clk);
    #1 chk({7'h0, sfull}, 8'h01);
    chk({3'h0, depth}, 8'h10);
    pulse(P_T0);
    pulse(P_FP);
    chk({7'h0, icall}, 8'h00);
    pulse(P_SR);
    @(posedge clk);
    pulse(P_FP);
    chk({7'h0, icall}, 8'h01);
    chk(vec, 8'h08);
  endtask : t_stack

  // power-down flags and wake, including a flag already set on entry
  task automatic t_halt();
    do_reset();
    pulse(P_WT);
    rd(8'h0a, 8'h20);
    pulse(P_HL);
    chk({7'h0, halted}, 8'h01);
    rd(8'h0a, 8'h10);
    wr(8'h0a, 8'h00);
    rd(8'h0a, 8'h10);
    pulse(P_T1);
    chk({6'h0, wake, halted}, 8'h02);
    pulse(P_HL);
    pulse(P_T1);
    chk({6'h0, wake, halted}, 8'h01);
    pulse(P_WT);
    pulse(P_WC);
    rd(8'h0a, 8'h00);
  endtask : t_halt

  // enable low freezes every register, writes and events included
  task automatic t_freeze();
    do_reset();
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h0b, 8'h0f);
    pulse(P_T0 | P_HL);
    chk({7'h0, halted}, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    rd(8'h0b, 8'h00);
    rd(8'h0a, 8'h00);
  endtask : t_freeze

  // main sequence
  initial begin
    {ce, pin_n, srst} = 3'b111;
    {ovf0, ovf1, fp, we, halt, wclr, wto, call_r, sret_r, iret_r} = '0;
    {addr, wdata} = 16'h0000;
    alu = '0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_ext();
    t_prio();
    t_stack();
    t_halt();
    t_freeze();
    wrap_up();
  end
endmodule : tb_cif_core
